//--- hw/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz bus clock
// Notes: register offsets are byte addresses of aligned words
package adc_ctrl_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h08;
  localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_PORT_DATA = 8'h10;
  localparam logic [7:0] OFS_PORT_DIR = 8'h14;
  localparam logic [7:0] OFS_PORT_PINS = 8'h18;

  // =====================================================================
  // status/control fields
  localparam int DONE_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam logic [4:0] CHAN_RESET = 5'h1F;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1D;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1E;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
  localparam logic [4:0] CHAN_LAST_EXT = 5'h07;

  // =====================================================================
  // clock config fields
  localparam int DIV_LSB = 5;
  localparam int SRC_BIT = 4;
  localparam int JUST_LSB = 2;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] DIV_MAX = 3'h4;

  // =====================================================================
  // conversion timing
  localparam int RESULT_W = 10;
  localparam logic [4:0] CONV_CYCLES = 5'h10;

  typedef enum logic [1:0] {
    JUST_LEFT,
    JUST_RIGHT,
    JUST_LEFT_SIGNED,
    JUST_TRUNC8
  } justify_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } result_pair_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic sel;
  } bus_req_t;

endpackage

//--- hw/adc_ctrl.sv
// Purpose: control, sequencing and result formatting of a 10-bit SAR converter
// Assumes: analog core samples sel_chan_o on start and returns a code with done
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Contract
// - produce a 10-bit result for the currently selected input
// - mux routes exactly one of eight channels by channel select
// - on completion load result, then set done flag or raise interrupt
// - selected shared pin forced input; port writes do not affect it
// - port read of the pin in use by converter returns zero
// - unselected shared pins stay under normal port control
// - high reference gives all ones, low reference gives all zeros
// - every status/control write starts a new conversion; a write that selects power off (5'h1F) leaves the sequencer idle
// - each conversion completes in 16 to 17 converter clocks
// - continuous mode overwrites results whether read or not
// - continuous mode keeps converting until the continuous bit clears
// - interrupts off: done flag set per conversion until data read
// - single mode: exactly one conversion per status/control write
// - two justify bits pick one of four result formats
// - left justified: eight msbs high, two lsbs low
// - interlocked formats: low after high, else new results blocked
// - right justified: two msbs high, eight lsbs low
// - left signed: as left justified with result msb inverted
// - truncation: eight msbs low, lsbs dropped, no interlock
// - interrupt enabled: flag reads zero; irq clears on data read or write
// - five-bit select: 0-7 external, two references, all ones powers off
// - one conversion needed to stabilise after leaving power off
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic alt_clk_tick_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [9:0] core_result_i,
  output logic [4:0] sel_chan_o,
  output logic core_power_down_o,
  output logic core_start_o,
  output logic conv_irq_o,
  output logic result_stable_o,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_n_o
);

  // =====================================================================
  // functions
  function automatic logic is_external(input logic [4:0] ch);
    is_external = (ch <= CHAN_LAST_EXT);
  endfunction

  function automatic logic [7:0] chan_mask(input logic [4:0] ch);
    chan_mask = is_external(ch) ? (8'h01 << ch[2:0]) : 8'h00;
  endfunction

  function automatic result_pair_t format_result(input logic [9:0] r, input justify_t j);
    case (j)
      JUST_LEFT: format_result = '{hi: r[9:2], lo: {r[1:0], 6'h00}};
      JUST_RIGHT: format_result = '{hi: {6'h00, r[9:8]}, lo: r[7:0]};
      JUST_LEFT_SIGNED: format_result = '{hi: {~r[9], r[8:2]}, lo: {r[1:0], 6'h00}};
      JUST_TRUNC8: format_result = '{hi: 8'h00, lo: r[9:2]};
      default: format_result = '{hi: 8'h00, lo: 8'h00};
    endcase
  endfunction

  // =====================================================================
  // registers
  logic done_flag;
  logic irq_en;
  logic cont_mode;
  logic [4:0] chan;
  logic [2:0] div_sel;
  logic src_sel;
  justify_t justify;
  logic [7:0] port_data;
  logic [7:0] port_dir;
  result_pair_t result;
  logic hi_read_pending;
  logic stable;

  // =====================================================================
  // bus slave: capture address phase
  bus_req_t req;
  logic wr_phase;
  logic rd_phase;
  logic ctl_write;
  logic data_read;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req <= '{addr: 8'h00, write: 1'b0, sel: 1'b0};
    else if (hready_i)
      req <= '{addr: haddr_i[7:0], write: hwrite_i,
               sel: hsel_i && htrans_i[1] && (hsize_i == 3'h2)};
  end

  assign wr_phase = req.sel && req.write;
  assign rd_phase = req.sel && !req.write;
  assign ctl_write = wr_phase && (req.addr == OFS_STATUS_CONTROL);
  assign data_read = rd_phase &&
                     ((req.addr == OFS_RESULT_HIGH) || (req.addr == OFS_RESULT_LOW));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // =====================================================================
  // control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_en <= 1'b0;
      cont_mode <= 1'b0;
      chan <= CHAN_RESET;
    end
    else if (ctl_write)
    begin
      irq_en <= hwdata_i[IRQ_EN_BIT];
      cont_mode <= hwdata_i[CONT_BIT];
      chan <= hwdata_i[CHAN_LSB +: CHAN_W];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_sel <= DIV_RESET;
      src_sel <= 1'b0;
      justify <= JUST_LEFT;
    end
    else if (wr_phase && req.addr == OFS_CLOCK_CONFIG)
    begin
      div_sel <= (hwdata_i[DIV_LSB +: 3] > DIV_MAX) ? DIV_MAX : hwdata_i[DIV_LSB +: 3];
      src_sel <= hwdata_i[SRC_BIT];
      justify <= justify_t'(hwdata_i[JUST_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_data <= 8'h00;
      port_dir <= 8'h00;
    end
    else
    begin
      if (wr_phase && req.addr == OFS_PORT_DATA)
        port_data <= hwdata_i[7:0];
      if (wr_phase && req.addr == OFS_PORT_DIR)
        port_dir <= hwdata_i[7:0];
    end
  end

  // =====================================================================
  // converter clock divider
  logic [15:0] div_cnt;
  logic src_tick;
  logic conv_tick;
  logic [15:0] div_mask;

  assign src_tick = src_sel ? alt_clk_tick_i : 1'b1;
  assign div_mask = 16'h00FF >> (4'h8 - {1'b0, div_sel});

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_cnt <= 16'h0000;
    else if (src_tick)
      div_cnt <= div_cnt + 16'h0001;
  end

  assign conv_tick = src_tick && ((div_cnt & div_mask) == div_mask);

  // =====================================================================
  // conversion sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_FINISH} seq_state_t;
  seq_state_t state;
  logic [4:0] tick_cnt;
  logic finish;
  logic store_ok;

  assign finish = (state == ST_FINISH);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      tick_cnt <= 5'h00;
    end
    else if (ctl_write)
    begin
      state <= (hwdata_i[CHAN_LSB +: CHAN_W] == CHAN_POWER_OFF) ? ST_IDLE : ST_CONVERT;
      tick_cnt <= 5'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
          state <= ST_IDLE;
        ST_CONVERT:
          if (conv_tick)
          begin
            if (tick_cnt == CONV_CYCLES - 5'h01)
              state <= ST_FINISH;
            tick_cnt <= tick_cnt + 5'h01;
          end
        ST_FINISH:
        begin
          tick_cnt <= 5'h00;
          state <= (cont_mode && chan != CHAN_POWER_OFF) ? ST_CONVERT : ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_start_o <= 1'b0;
      sel_chan_o <= CHAN_RESET;
      core_power_down_o <= 1'b1;
    end
    else
    begin
      core_start_o <= ctl_write || (finish && cont_mode);
      sel_chan_o <= chan;
      core_power_down_o <= (chan == CHAN_POWER_OFF);
    end
  end

  // stability after power off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stable <= 1'b0;
    else if (chan == CHAN_POWER_OFF)
      stable <= 1'b0;
    else if (finish)
      stable <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_stable_o <= 1'b0;
    else
      result_stable_o <= stable;
  end

  // =====================================================================
  // result store with read interlock
  assign store_ok = (justify == JUST_TRUNC8) || !hi_read_pending;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result <= '{hi: 8'h00, lo: 8'h00};
    else if (finish && store_ok)
      result <= format_result(core_result_i, justify);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hi_read_pending <= 1'b0;
    else if (rd_phase && req.addr == OFS_RESULT_LOW)
      hi_read_pending <= 1'b0;
    else if (rd_phase && req.addr == OFS_RESULT_HIGH && justify != JUST_TRUNC8)
      hi_read_pending <= 1'b1;
  end

  // =====================================================================
  // completion flag and interrupt; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_flag <= 1'b0;
    else if (finish && store_ok && !irq_en)
      done_flag <= 1'b1;
    else if (data_read || irq_en)
      done_flag <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      conv_irq_o <= 1'b0;
    else if (finish && store_ok && irq_en)
      conv_irq_o <= 1'b1;
    else if (data_read || ctl_write)
      conv_irq_o <= 1'b0;
  end

  // =====================================================================
  // shared port pins
  logic [7:0] adc_pin;

  assign adc_pin = chan_mask(chan);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_o <= 8'h00;
      pin_oe_n_o <= 8'hFF;
    end
    else
    begin
      pin_out_o <= port_data & ~adc_pin;
      pin_oe_n_o <= ~(port_dir & ~adc_pin);
    end
  end

  // =====================================================================
  // read data
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      OFS_STATUS_CONTROL:
        next_rdata = {24'h000000, done_flag && !irq_en, irq_en, cont_mode, chan};
      OFS_RESULT_HIGH:
        next_rdata = {24'h000000, result.hi};
      OFS_RESULT_LOW:
        next_rdata = {24'h000000, result.lo};
      OFS_CLOCK_CONFIG:
        next_rdata = {24'h000000, div_sel, src_sel, justify, 2'h0};
      OFS_PORT_DATA:
        next_rdata = {24'h000000, port_data};
      OFS_PORT_DIR:
        next_rdata = {24'h000000, port_dir};
      OFS_PORT_PINS:
        next_rdata = {24'h000000, pin_in_i & ~adc_pin};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
      hrdata_o <= next_rdata;
  end

endmodule

//--- verif/analog_core_model.sv
// Purpose: analog core and shared pin partner model
// Assumes: pins carry pull-ups when nobody drives them
// Notes: each channel returns a fixed code
`timescale 1ns/100ps
module analog_core_model
(
  input wire logic [4:0] sel_chan_i,
  input wire logic core_power_down_i,
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_n_i,
  output logic [9:0] core_result_o,
  output logic [7:0] pin_in_o
);
  // ====
  // one input at a time reaches the converter
  assign core_result_o = core_power_down_i ? 10'h2AA : sel_chan_i == 5'h1D ? 10'h3FF :
    sel_chan_i == 5'h1E ? 10'h000 : {sel_chan_i[2:0], 7'h55};
  // undriven pins float high
  assign pin_in_o = pin_out_i | pin_oe_n_i;
endmodule

//--- verif/adc_ctrl_asserts.sv
// Purpose: port checker for adc_ctrl
// Assumes: word accesses with upper address bits zero
// Notes: bound to every adc_ctrl instance
`timescale 1ns/100ps
module adc_ctrl_asserts
  import adc_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic core_start_o,
  input wire logic conv_irq_o,
  input wire logic result_stable_o,
  input wire logic [4:0] sel_chan_o,
  input wire logic [7:0] pin_oe_n_o
);
  logic tk;
  logic [4:0] since;
  logic [2:0] sel_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign tk = hsel_i && hready_i && htrans_i == 2'h2 && hsize_i == 3'h2;
  // ====
  // cycles since the last start pulse, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i || core_start_o)
      since <= 5'h00;
    else if (since != 5'h1F)
      since <= since + 5'h01;
    sel_q <= sel_chan_o[2:0];
  end
  sequence s_wr_ctrl;
    tk && hwrite_i && haddr_i[7:0] == OFS_STATUS_CONTROL;
  endsequence
  sequence s_rd_res;
    tk && !hwrite_i && (haddr_i[7:0] == OFS_RESULT_HIGH || haddr_i[7:0] == OFS_RESULT_LOW);
  endsequence
  property p_start;
    s_wr_ctrl ##1 hwdata_i[4:0] != CHAN_POWER_OFF |=> core_start_o;
  endproperty
  property p_irq_wr;
    conv_irq_o ##0 s_wr_ctrl |-> ##[2:3] !conv_irq_o;
  endproperty
  property p_irq_rd;
    conv_irq_o ##0 s_rd_res |-> ##[1:3] !conv_irq_o;
  endproperty
  property p_irq_time;
    $rose(conv_irq_o) |-> $past(since) >= 5'h0E;
  endproperty
  property p_stable;
    $rose(result_stable_o) |-> $past(since) >= 5'h0E;
  endproperty
  property p_oe;
    sel_chan_o <= CHAN_LAST_EXT && $stable(sel_chan_o) |-> pin_oe_n_o[sel_chan_o[2:0]];
  endproperty
  property p_pin_rd;
    tk && !hwrite_i && haddr_i[7:0] == OFS_PORT_PINS && sel_chan_o <= CHAN_LAST_EXT
      |=> !hrdata_o[sel_q];
  endproperty
  property p_rst;
    $past(rst_i) |-> !core_start_o && !conv_irq_o && sel_chan_o == CHAN_RESET;
  endproperty
  a_start: assert property (p_start) else $error("no start after control write");
  a_irq_wr: assert property (p_irq_wr) else $error("irq kept after control write");
  a_irq_rd: assert property (p_irq_rd) else $error("irq kept after data read");
  a_irq_time: assert property (p_irq_time) else $error("conversion ended early");
  a_stable: assert property (p_stable) else $error("stable before full conversion");
  a_oe: assert property (p_oe) else $error("selected pin driven");
  a_pin_rd: assert property (p_pin_rd) else $error("selected pin read nonzero");
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule
bind adc_ctrl adc_ctrl_asserts u_adc_ctrl_asserts (.clk_i, .rst_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .core_start_o,
  .conv_irq_o, .result_stable_o, .sel_chan_o, .pin_oe_n_o);

//--- verif/adc_ctrl_bench.sv
// Purpose: self-checking bench for adc_ctrl
// Assumes: zero wait AHB-Lite slave, word transfers
// Notes: covers formats, pins, timing and modes
`timescale 1ns/100ps
module adc_ctrl_bench;
  import adc_ctrl_pkg::*;
  logic clk_i, rst_i, alt_clk_tick_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic core_power_down_o, core_start_o, conv_irq_o, result_stable_o;
  logic [1:0] htrans_i, alt_cnt;
  logic [2:0] hsize_i;
  logic [4:0] sel_chan_o;
  logic [9:0] core_result_i;
  logic [15:0] e;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic [7:0] pin_in_i, pin_out_o, pin_oe_n_o;
  logic [4:0] chs [3] = '{5'h05, 5'h1D, 5'h1E};
  logic [31:0] cfgs [3] = '{32'h00, 32'h20, 32'h10};
  int pers [3] = '{1, 2, 4};
  int mismatches, samples_checked, cyc, c;
  assign hready_i = hreadyout_o;
  adc_ctrl u_adc_ctrl (.clk_i, .rst_i, .alt_clk_tick_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .core_result_i, .sel_chan_o, .core_power_down_o, .core_start_o, .conv_irq_o,
    .result_stable_o, .pin_in_i, .pin_out_o, .pin_oe_n_o);
  analog_core_model u_analog_core_model (.sel_chan_i(sel_chan_o),
    .core_power_down_i(core_power_down_o), .pin_out_i(pin_out_o),
    .pin_oe_n_i(pin_oe_n_o), .core_result_o(core_result_i), .pin_in_o(pin_in_i));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // alternate source ticks once every four bus cycles
  always @(posedge clk_i)
  begin
    alt_cnt <= alt_cnt + 2'h1;
    alt_clk_tick_i <= alt_cnt == 2'h3;
  end
  // ====
  // tasks
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        mismatches++;
        conclude();
      end
      @(posedge clk_i);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    edge_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    edge_ready();
    q = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    bus(a, 1'b0, 32'h0);
    chk(n, x, q);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    q = 32'h0;
    while (q[DONE_FLAG_BIT] !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        mismatches++;
        conclude();
      end
      bus(OFS_STATUS_CONTROL, 1'b0, 32'h0);
    end
  endtask
  task automatic wait_irq();
    cyc = 0;
    while (conv_irq_o !== 1'b1)
    begin
      cyc++;
      if (cyc > 300)
      begin
        mismatches++;
        conclude();
      end
      @(posedge clk_i);
    end
  endtask
  task automatic count_starts();
    c = 0;
    repeat (100)
    begin
      @(posedge clk_i);
      if (core_start_o === 1'b1)
        c++;
    end
  endtask
  // expected high and low bytes for a justify mode and channel
  function automatic logic [15:0] fmt(input logic [1:0] j, input logic [4:0] ch);
    logic [9:0] r;
    r = ch == 5'h1D ? 10'h3FF : ch == 5'h1E ? 10'h000 : {ch[2:0], 7'h55};
    case (j)
      2'h1: fmt = {6'h0, r};
      2'h2: fmt = {~r[9], r[8:0], 6'h0};
      2'h3: fmt = {8'h0, r[9:2]};
      default: fmt = {r, 6'h0};
    endcase
  endfunction
  // ====
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {alt_clk_tick_i, alt_cnt, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = '0;
    hsize_i = 3'h2;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STATUS_CONTROL, 32'h1F, "ctrl reset");
    // a byte-sized write must be ignored
    hsize_i <= 3'h0;
    bus(OFS_CLOCK_CONFIG, 1'b1, 32'hFC);
    hsize_i <= 3'h2;
    rd(OFS_CLOCK_CONFIG, 32'h0, "cfg reset");
    rd(8'h1C, 32'h0, "unmapped");
    chk("power down", 32'h1, {31'h0, core_power_down_o});
    $display("reset test done");
    for (int j = 0; j < 4; j++)
    begin
      bus(OFS_CLOCK_CONFIG, 1'b1, 32'(j << 2));
      foreach (chs[i])
      begin
        e = fmt(2'(j), chs[i]);
        bus(OFS_STATUS_CONTROL, 1'b1, {27'h0, chs[i]});
        wait_done();
        if (j != 3)
          rd(OFS_RESULT_HIGH, {24'h0, e[15:8]}, "high");
        rd(OFS_RESULT_LOW, {24'h0, e[7:0]}, "low");
        rd(OFS_STATUS_CONTROL, {27'h0, chs[i]}, "flag clear");
      end
    end
    chk("stable", 32'h1, {31'h0, result_stable_o});
    $display("format test done");
    bus(OFS_PORT_DIR, 1'b1, 32'hFF);
    bus(OFS_PORT_DATA, 1'b1, 32'h5A);
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h03);
    wait_done();
    chk("oe_n", 32'h08, {24'h0, pin_oe_n_o});
    chk("drive", 32'h52, {24'h0, pin_out_o});
    chk("sel", 32'h03, {27'h0, sel_chan_o});
    chk("power up", 32'h0, {31'h0, core_power_down_o});
    rd(OFS_PORT_PINS, 32'h52, "pins");
    bus(OFS_PORT_DATA, 1'b1, 32'hFF);
    chk("oe_n held", 32'h08, {24'h0, pin_oe_n_o});
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h1F);
    repeat (3) @(posedge clk_i);
    chk("oe_n off", 32'h00, {24'h0, pin_oe_n_o});
    chk("power off", 32'h1, {31'h0, core_power_down_o});
    $display("pin test done");
    for (int k = 0; k < 3; k++)
    begin
      bus(OFS_CLOCK_CONFIG, 1'b1, cfgs[k]);
      bus(OFS_STATUS_CONTROL, 1'b1, 32'h42);
      wait_irq();
      chk("time", 32'h1, {31'h0, cyc > 15 * pers[k] && cyc <= 17 * pers[k] + 6});
      rd(OFS_STATUS_CONTROL, 32'h42, "flag ien");
      rd(OFS_RESULT_HIGH, 32'h55, "high ien");
      rd(OFS_RESULT_LOW, 32'h40, "low ien");
      chk("irq read", 32'h0, {31'h0, conv_irq_o});
    end
    bus(OFS_CLOCK_CONFIG, 1'b1, 32'h0);
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h42);
    repeat (8) @(posedge clk_i);
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h42);
    wait_irq();
    chk("restart", 32'h1, {31'h0, cyc >= 16});
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h5F);
    @(posedge clk_i);
    chk("irq write", 32'h0, {31'h0, conv_irq_o});
    $display("timing test done");
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h01);
    wait_done();
    rd(OFS_RESULT_HIGH, 32'h35, "lock high");
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h02);
    repeat (40) @(posedge clk_i);
    rd(OFS_STATUS_CONTROL, 32'h02, "lock flag");
    rd(OFS_RESULT_LOW, 32'h40, "lock low");
    rd(OFS_RESULT_HIGH, 32'h35, "lock kept");
    rd(OFS_RESULT_LOW, 32'h40, "lock free");
    // unread channel 3 results are left for channel 4 to overwrite
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h23);
    repeat (40) @(posedge clk_i);
    rd(OFS_STATUS_CONTROL, 32'hA3, "cont flag");
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h24);
    count_starts();
    chk("continuous", 32'h1, {31'h0, c >= 5});
    rd(OFS_RESULT_HIGH, 32'h95, "overwrite");
    bus(OFS_STATUS_CONTROL, 1'b1, 32'h04);
    count_starts();
    chk("single", 32'h1, {31'h0, c == 1});
    $display("mode test done");
    conclude();
  end
endmodule
